// ==== hw/paf_filter.v ====
// Function
// - matching entry action permit forwards frame, deny drops it.
// - up to 247 entries, numbered 1 to 247.
// - vlan match is wildcard (binding: stored as id 0) or one vlan id 1 to 4094 equal to frame.
// - type selector ipv4, non-ipv4 or binding picks matched field set.
// - address, fragment, protocol and l4 port fields used only for ipv4.
// - source and destination address: wildcard or address with mask.
// - mask is any bit pattern, not only a contiguous prefix.
// - fragment option off by default; when on, frame fragment examined.
// - protocol wildcard or number; icmp 1, igmp 2, tcp 6, udp 17.
// - any protocol 0 to 255 loadable, full value compared.
// - tcp port wildcard or number; ftp 21, http 80.
// - any tcp port 0 to 65535 loadable, full 16 bits compared.
// - udp port wildcard or number; dhcp 67, tftp 69, netbios 137.
// - any udp port 0 to 65535 loadable, full 16 bits compared.
// - ingress port 1 to 26 must equal frame port; 0 is wildcard except in binding entries.
// - ethertype used only for non-ipv4 entries.
// - ethertype wildcard or value; arp 0x0806, ipx 0x8137.
// - any ethertype 0 to 0xFFFF loadable, full 16 bits compared.
// - filtering driven by a table keyed by header fields.
// - binding entry hits only if address, mac, vlan, port all match; its deny bit then decides.
`timescale 1ns/1ps
`default_nettype none
`include "paf_filter_regs.vh"

module paf_filter (
   input wire clk_sys,
   input wire rst,
   input wire [5:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   input wire frm_valid,
   output reg frm_ready,
   input wire [11:0] frm_vid,
   input wire [4:0] frm_port,
   input wire [15:0] frm_etype,
   input wire frm_is_ipv4,
   input wire [31:0] frm_sip,
   input wire [31:0] frm_dip,
   input wire frm_frag,
   input wire [7:0] frm_proto,
   input wire [15:0] frm_l4_port,
   input wire [47:0] frm_smac,
   output reg vrd_valid,
   output reg vrd_forward,
   output reg [7:0] vrd_entry_number
);

   localparam ST_IDLE = 1'b0;
   localparam ST_SCAN = 1'b1;

   // -----------------------------------------------------------------
   // entry table and staging registers
   // -----------------------------------------------------------------
   // table of entries
   reg [`PAF_ENTRY_W-1:0] entry_mem [0:`PAF_LAST_IDX];
   reg [`PAF_NUM_ENTRIES-1:0] entry_used_r;

   reg [31:0] ctrl_r;
   reg [31:0] flags_r;
   reg [31:0] sip_r;
   reg [31:0] smsk_r;
   reg [31:0] dip_r;
   reg [31:0] dmsk_r;
   reg [7:0] proto_r;
   reg [15:0] tcp_r;
   reg [15:0] udp_r;
   reg [15:0] etype_r;
   reg [47:0] mac_r;
   reg [31:0] fwd_cnt_r;
   reg [31:0] drop_cnt_r;
   reg cmd_err_r;
   reg last_drop_r;
   reg [7:0] last_num_r;

   // -----------------------------------------------------------------
   // avalon slave: one wait state, then the answer
   // -----------------------------------------------------------------
   wire bus_req = avs_read | avs_write;
   wire bus_take = bus_req & ~avs_waitrequest;
   wire wr_take = avs_write & ~avs_waitrequest;
   reg [31:0] rd_mux;
   wire frm_ready_n = ~frm_ready;

   always @* begin
      case (avs_address)
         `PAF_OFS_CTRL: rd_mux = ctrl_r;
         `PAF_OFS_STATUS: rd_mux = {16'h0000, last_num_r, 5'h00,
            last_drop_r, cmd_err_r, frm_ready_n};
         `PAF_OFS_FLAGS: rd_mux = flags_r;
         `PAF_OFS_SIP: rd_mux = sip_r;
         `PAF_OFS_SMSK: rd_mux = smsk_r;
         `PAF_OFS_DIP: rd_mux = dip_r;
         `PAF_OFS_DMSK: rd_mux = dmsk_r;
         `PAF_OFS_PROTO: rd_mux = {24'h000000, proto_r};
         `PAF_OFS_L4PORTS: rd_mux = {udp_r, tcp_r};
         `PAF_OFS_ETYPE: rd_mux = {16'h0000, etype_r};
         `PAF_OFS_MAC_LO: rd_mux = mac_r[31:0];
         `PAF_OFS_MAC_HI: rd_mux = {16'h0000, mac_r[47:32]};
         `PAF_OFS_FWD_CNT: rd_mux = fwd_cnt_r;
         `PAF_OFS_DROP_CNT: rd_mux = drop_cnt_r;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else if (bus_req && avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
         avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // entry commit
   // -----------------------------------------------------------------
   wire cmd_wr = wr_take && (avs_address == `PAF_OFS_CMD);
   wire [7:0] cmd_num = avs_writedata[`PAF_CMD_NUM_HI:0];
   wire cmd_ok = (cmd_num != 8'h00) && (cmd_num <= `PAF_NUM_ENTRIES);
   wire [7:0] cmd_idx = cmd_num - 8'h01;
   wire [1:0] st_type = flags_r[2:1];
   wire st_bind = (st_type == `PAF_TYPE_BIND);
   // binding wildcard vlan becomes id zero
   wire [11:0] st_vid = (st_bind && flags_r[`PAF_FL_ANY_VLAN]) ?
      12'h000 : flags_r[27:16];
   wire st_anyv = flags_r[`PAF_FL_ANY_VLAN] & ~st_bind;
   wire [`PAF_ENTRY_W-1:0] st_entry = {mac_r, etype_r,
      flags_r[`PAF_FL_ANY_ETYPE], flags_r[15:11],
      udp_r, flags_r[`PAF_FL_ANY_UDP], tcp_r, flags_r[`PAF_FL_ANY_TCP],
      proto_r, flags_r[`PAF_FL_ANY_PROTO], flags_r[`PAF_FL_FRAG],
      dmsk_r, dip_r, flags_r[`PAF_FL_ANY_DIP],
      smsk_r, sip_r, flags_r[`PAF_FL_ANY_SIP],
      st_vid, st_anyv, st_type, flags_r[`PAF_FL_DENY], 1'b1};

   always @(posedge clk_sys) begin
      if (cmd_wr && cmd_ok && avs_writedata[`PAF_CMD_WRITE]) begin
         entry_mem[cmd_idx] <= st_entry;
      end
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         entry_used_r <= {`PAF_NUM_ENTRIES{1'b0}};
         cmd_err_r <= 1'b0;
      end else if (cmd_wr) begin
         cmd_err_r <= ~cmd_ok;
         if (cmd_ok && avs_writedata[`PAF_CMD_DELETE]) begin
            entry_used_r[cmd_idx] <= 1'b0;
         end else if (cmd_ok && avs_writedata[`PAF_CMD_WRITE]) begin
            entry_used_r[cmd_idx] <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // staging register writes
   // -----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rst) begin
         ctrl_r <= `PAF_RST_CTRL;
         flags_r <= `PAF_RST_FLAGS;
         sip_r <= 32'h0000_0000;
         smsk_r <= `PAF_RST_MASK;
         dip_r <= 32'h0000_0000;
         dmsk_r <= `PAF_RST_MASK;
         proto_r <= 8'h00;
         tcp_r <= 16'h0000;
         udp_r <= 16'h0000;
         etype_r <= 16'h0000;
         mac_r <= `PAF_RST_MAC;
      end else if (wr_take) begin
         case (avs_address)
            `PAF_OFS_CTRL: ctrl_r <= {30'h00000000,
               avs_writedata[`PAF_CTRL_CLR], avs_writedata[`PAF_CTRL_EN]};
            `PAF_OFS_FLAGS: flags_r <= {4'h0, avs_writedata[27:0]};
            `PAF_OFS_SIP: sip_r <= avs_writedata;
            `PAF_OFS_SMSK: smsk_r <= avs_writedata;
            `PAF_OFS_DIP: dip_r <= avs_writedata;
            `PAF_OFS_DMSK: dmsk_r <= avs_writedata;
            `PAF_OFS_PROTO: proto_r <= avs_writedata[7:0];
            `PAF_OFS_L4PORTS: begin
               tcp_r <= avs_writedata[15:0];
               udp_r <= avs_writedata[31:16];
            end
            `PAF_OFS_ETYPE: etype_r <= avs_writedata[15:0];
            `PAF_OFS_MAC_LO: mac_r[31:0] <= avs_writedata;
            `PAF_OFS_MAC_HI: mac_r[47:32] <= avs_writedata[15:0];
            default: ctrl_r <= ctrl_r;
         endcase
      end else begin
         // clear bit is a one-shot
         ctrl_r[`PAF_CTRL_CLR] <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // frame capture and scan
   // -----------------------------------------------------------------
   reg state_r;
   reg [7:0] idx_r;
   reg [11:0] f_vid_r;
   reg [4:0] f_port_r;
   reg [15:0] f_etype_r;
   reg f_ip_r;
   reg [31:0] f_sip_r;
   reg [31:0] f_dip_r;
   reg f_frag_r;
   reg [7:0] f_proto_r;
   reg [15:0] f_l4_r;
   reg [47:0] f_mac_r;

   wire [`PAF_ENTRY_W-1:0] e = entry_mem[idx_r];
   wire [1:0] e_type = e[`PAF_E_TYPE];

   // binding always compares, wildcard stored as zero
   wire m_vid = e[`PAF_E_ANYV] || (e[`PAF_E_VID] == f_vid_r);
   wire m_port = (e[`PAF_E_PORT] == 5'h00) ||
      (e[`PAF_E_PORT] == f_port_r);
   // mask taken bit by bit, no prefix check
   wire m_sip = e[`PAF_E_ANYS] ||
      ((f_sip_r & e[`PAF_E_SMSK]) == (e[`PAF_E_SIP] & e[`PAF_E_SMSK]));
   wire m_dip = e[`PAF_E_ANYD] ||
      ((f_dip_r & e[`PAF_E_DMSK]) == (e[`PAF_E_DIP] & e[`PAF_E_DMSK]));
   // fragment examined only when option set
   wire m_frag = ~e[`PAF_E_FRAG] | f_frag_r;
   wire m_proto = e[`PAF_E_ANYP] || (e[`PAF_E_PROTO] == f_proto_r);
   // tcp port applies to tcp frames
   wire m_tcp = e[`PAF_E_ANYT] || ((f_proto_r == `PAF_PROTO_TCP) &&
      (e[`PAF_E_TCP] == f_l4_r));
   // udp port applies to udp frames
   wire m_udp = e[`PAF_E_ANYU] || ((f_proto_r == `PAF_PROTO_UDP) &&
      (e[`PAF_E_UDP] == f_l4_r));
   wire m_etype = e[`PAF_E_ANYE] || (e[`PAF_E_ETYPE] == f_etype_r);
   // address, mac, vlan and port all required
   wire m_bind = f_ip_r && (e[`PAF_E_SIP] == f_sip_r) &&
      (e[`PAF_E_MAC] == f_mac_r) && (e[`PAF_E_VID] == f_vid_r) &&
      (e[`PAF_E_PORT] == f_port_r);

   // ip fields only for ipv4 entries
   reg m_type;
   always @* begin
      case (e_type)
         `PAF_TYPE_IPV4: m_type = f_ip_r && m_sip && m_dip && m_frag &&
            m_proto && m_tcp && m_udp && m_vid && m_port;
         `PAF_TYPE_NONIP: m_type = ~f_ip_r && m_etype && m_vid && m_port;
         `PAF_TYPE_BIND: m_type = m_bind;
         default: m_type = 1'b0;
      endcase
   end

   wire hit = entry_used_r[idx_r] && m_type;
   wire last = (idx_r == `PAF_LAST_IDX);
   wire ctrl_en = ctrl_r[`PAF_CTRL_EN];

   always @(posedge clk_sys) begin
      if (rst) begin
         state_r <= ST_IDLE;
         idx_r <= 8'h00;
         frm_ready <= 1'b0;
         vrd_valid <= 1'b0;
         vrd_forward <= 1'b1;
         vrd_entry_number <= 8'h00;
         last_drop_r <= 1'b0;
         last_num_r <= 8'h00;
         f_vid_r <= 12'h000;
         f_port_r <= 5'h00;
         f_etype_r <= 16'h0000;
         f_ip_r <= 1'b0;
         f_sip_r <= 32'h0000_0000;
         f_dip_r <= 32'h0000_0000;
         f_frag_r <= 1'b0;
         f_proto_r <= 8'h00;
         f_l4_r <= 16'h0000;
         f_mac_r <= 48'h0000_0000_0000;
      end else begin
         vrd_valid <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               frm_ready <= 1'b1;
               if (frm_valid && frm_ready) begin
                  frm_ready <= 1'b0;
                  state_r <= ST_SCAN;
                  idx_r <= 8'h00;
                  f_vid_r <= frm_vid;
                  f_port_r <= frm_port;
                  f_etype_r <= frm_etype;
                  f_ip_r <= frm_is_ipv4;
                  f_sip_r <= frm_sip;
                  f_dip_r <= frm_dip;
                  f_frag_r <= frm_frag;
                  f_proto_r <= frm_proto;
                  f_l4_r <= frm_l4_port;
                  f_mac_r <= frm_smac;
               end
            end
            ST_SCAN: begin
               // lowest number first, no match forwards
               if (!ctrl_en || hit || last) begin
                  state_r <= ST_IDLE;
                  vrd_valid <= 1'b1;
                  vrd_forward <= ~(ctrl_en && hit && e[`PAF_E_DENY]);
                  vrd_entry_number <= (ctrl_en && hit) ?
                     idx_r + 8'h01 : 8'h00;
                  last_drop_r <= ctrl_en && hit && e[`PAF_E_DENY];
                  last_num_r <= (ctrl_en && hit) ? idx_r + 8'h01 : 8'h00;
               end else begin
                  idx_r <= idx_r + 8'h01;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // verdict counters
   // -----------------------------------------------------------------
   always @(posedge clk_sys) begin
      if (rst || ctrl_r[`PAF_CTRL_CLR]) begin
         fwd_cnt_r <= 32'h0000_0000;
         drop_cnt_r <= 32'h0000_0000;
      end else if (vrd_valid && vrd_forward) begin
         fwd_cnt_r <= fwd_cnt_r + 32'h0000_0001;
      end else if (vrd_valid) begin
         drop_cnt_r <= drop_cnt_r + 32'h0000_0001;
      end
   end

endmodule
`default_nettype wire

// ==== hw/paf_filter_regs.vh ====
`ifndef PAF_FILTER_REGS_VH
`define PAF_FILTER_REGS_VH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define PAF_OFS_CTRL     6'h00
`define PAF_OFS_STATUS   6'h04
`define PAF_OFS_CMD      6'h08
`define PAF_OFS_FLAGS    6'h0C
`define PAF_OFS_SIP      6'h10
`define PAF_OFS_SMSK     6'h14
`define PAF_OFS_DIP      6'h18
`define PAF_OFS_DMSK     6'h1C
`define PAF_OFS_PROTO    6'h20
`define PAF_OFS_L4PORTS  6'h24
`define PAF_OFS_ETYPE    6'h28
`define PAF_OFS_MAC_LO   6'h2C
`define PAF_OFS_MAC_HI   6'h30
`define PAF_OFS_FWD_CNT  6'h34
`define PAF_OFS_DROP_CNT 6'h38

// -----------------------------------------------------------------
// register fields
// -----------------------------------------------------------------
`define PAF_CTRL_EN       0
`define PAF_CTRL_CLR      1
`define PAF_CMD_NUM_HI    7
`define PAF_CMD_WRITE     8
`define PAF_CMD_DELETE    9
`define PAF_ST_BUSY       0
`define PAF_ST_CMD_ERR    1
`define PAF_ST_LAST_DROP  2
`define PAF_FL_DENY       0
`define PAF_FL_ANY_VLAN   3
`define PAF_FL_ANY_SIP    4
`define PAF_FL_ANY_DIP    5
`define PAF_FL_FRAG       6
`define PAF_FL_ANY_PROTO  7
`define PAF_FL_ANY_TCP    8
`define PAF_FL_ANY_UDP    9
`define PAF_FL_ANY_ETYPE  10

// reset values: permit, ipv4, every match a wildcard, port 0
`define PAF_RST_CTRL      32'h0000_0001
`define PAF_RST_FLAGS     32'h0000_07B8
`define PAF_RST_MAC       48'h0011_2233_4455
`define PAF_RST_MASK      32'hFFFF_FFFF

// -----------------------------------------------------------------
// entry table
// -----------------------------------------------------------------
`define PAF_NUM_ENTRIES   8'hF7
`define PAF_LAST_IDX      8'hF6
`define PAF_ENTRY_W       261
`define PAF_TYPE_IPV4     2'h0
`define PAF_TYPE_NONIP    2'h1
`define PAF_TYPE_BIND     2'h2
`define PAF_PROTO_TCP     8'h06
`define PAF_PROTO_UDP     8'h11

// entry bit positions
`define PAF_E_VALID   0
`define PAF_E_DENY    1
`define PAF_E_TYPE    3:2
`define PAF_E_ANYV    4
`define PAF_E_VID     16:5
`define PAF_E_ANYS    17
`define PAF_E_SIP     49:18
`define PAF_E_SMSK    81:50
`define PAF_E_ANYD    82
`define PAF_E_DIP     114:83
`define PAF_E_DMSK    146:115
`define PAF_E_FRAG    147
`define PAF_E_ANYP    148
`define PAF_E_PROTO   156:149
`define PAF_E_ANYT    157
`define PAF_E_TCP     173:158
`define PAF_E_ANYU    174
`define PAF_E_UDP     190:175
`define PAF_E_PORT    195:191
`define PAF_E_ANYE    196
`define PAF_E_ETYPE   212:197
`define PAF_E_MAC     260:213

`endif

// ==== tb/paf_filter_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module paf_filter_monitor (
   input wire clk_sys,
   input wire rst,
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   input wire frm_valid,
   input wire frm_ready,
   input wire vrd_valid,
   input wire vrd_forward,
   input wire [7:0] vrd_entry_number
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ----------------------------------------
   // bus handshake
   // ----------------------------------------
   AST_BUS_WAIT: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus access not answered after one wait cycle");
   AST_BUS_LOW_ONE: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_BUS_IDLE: assert property (
      !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest dropped without a request");
   // ----------------------------------------
   // frame port and verdict
   // ----------------------------------------
   AST_TAKE: assert property (
      frm_valid && frm_ready |=> !frm_ready && !vrd_valid)
      else $error("frame capture did not close the port");
   AST_VERDICT_BOUND: assert property (
      frm_valid && frm_ready |-> ##[2:248] vrd_valid)
      else $error("no verdict within the table scan");
   AST_VRD_PULSE: assert property (
      vrd_valid |=> !vrd_valid)
      else $error("verdict strobe longer than one cycle");
   AST_READY_BACK: assert property (
      vrd_valid |=> frm_ready)
      else $error("port not reopened after verdict");
   AST_NUM_RANGE: assert property (
      vrd_valid |-> vrd_entry_number <= 8'hF7)
      else $error("deciding entry number out of range");
   AST_NONE_FWD: assert property (
      vrd_valid && vrd_entry_number == 8'h00 |-> vrd_forward)
      else $error("unmatched frame not forwarded");
   AST_HOLD: assert property (
      !vrd_valid |-> $stable(vrd_forward) && $stable(vrd_entry_number))
      else $error("verdict changed without a strobe");
endmodule
bind paf_filter paf_filter_monitor i_mon (.clk_sys(clk_sys), .rst(rst),
   .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .frm_valid(frm_valid),
   .frm_ready(frm_ready), .vrd_valid(vrd_valid),
   .vrd_forward(vrd_forward), .vrd_entry_number(vrd_entry_number));
`default_nettype wire

// ==== tb/paf_parser_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module paf_parser_model (
   input wire logic clk_sys,
   input wire logic frm_ready,
   input wire logic vrd_valid,
   input wire logic vrd_forward,
   input wire logic [7:0] vrd_entry_number,
   output logic frm_valid,
   output logic [11:0] frm_vid,
   output logic [4:0] frm_port,
   output logic [15:0] frm_etype,
   output logic frm_is_ipv4,
   output logic [31:0] frm_sip,
   output logic [31:0] frm_dip,
   output logic frm_frag,
   output logic [7:0] frm_proto,
   output logic [15:0] frm_l4_port,
   output logic [47:0] frm_smac
);
   initial begin
      frm_valid = 1'b0;
      {frm_vid, frm_port, frm_etype, frm_is_ipv4, frm_sip, frm_dip,
       frm_frag, frm_proto, frm_l4_port, frm_smac} = '0;
   end
   task automatic send(input int gap, input logic [11:0] v,
      input logic [4:0] p, input logic [15:0] e, input logic i4,
      input logic [31:0] s, d, input logic fr, input logic [7:0] pr,
      input logic [15:0] l, input logic [47:0] m,
      output logic fwd, output logic [7:0] num);
      repeat (gap + 1) @(posedge clk_sys);
      {frm_vid, frm_port, frm_etype, frm_is_ipv4, frm_sip, frm_dip,
       frm_frag, frm_proto, frm_l4_port, frm_smac} <=
         {v, p, e, i4, s, d, fr, pr, l, m};
      frm_valid <= 1'b1;
      do @(posedge clk_sys); while (frm_ready !== 1'b1);
      frm_valid <= 1'b0;
      // released fields must not keep looking valid
      {frm_vid, frm_port, frm_etype, frm_is_ipv4, frm_sip, frm_dip,
       frm_frag, frm_proto, frm_l4_port, frm_smac} <=
         ~{v, p, e, i4, s, d, fr, pr, l, m};
      do @(posedge clk_sys); while (vrd_valid !== 1'b1);
      fwd = vrd_forward;
      num = vrd_entry_number;
   endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "paf_filter_regs.vh"
module tb_top;
   localparam logic [31:0] ANY = 32'h0000_07B8;
   logic clk_sys, rst, avs_read, avs_write;
   logic [5:0] avs_address;
   logic [31:0] avs_writedata;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, frm_valid, frm_ready, vrd_valid, vrd_forward;
   wire frm_is_ipv4, frm_frag;
   wire [7:0] vrd_entry_number, frm_proto;
   wire [11:0] frm_vid;
   wire [4:0] frm_port;
   wire [15:0] frm_etype, frm_l4_port;
   wire [31:0] frm_sip, frm_dip;
   wire [47:0] frm_smac;
   int err_total, checked, cyc, fgap;
   logic [11:0] fv;
   logic [4:0] fp;
   logic [15:0] fe, fl;
   logic f4, ff;
   logic [31:0] fs;
   logic [7:0] fpr;
   logic [47:0] fm;
   paf_filter i_dut (.clk_sys(clk_sys), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .frm_valid(frm_valid), .frm_ready(frm_ready), .frm_vid(frm_vid),
      .frm_port(frm_port), .frm_etype(frm_etype),
      .frm_is_ipv4(frm_is_ipv4), .frm_sip(frm_sip), .frm_dip(frm_dip),
      .frm_frag(frm_frag), .frm_proto(frm_proto),
      .frm_l4_port(frm_l4_port), .frm_smac(frm_smac),
      .vrd_valid(vrd_valid), .vrd_forward(vrd_forward),
      .vrd_entry_number(vrd_entry_number));
   paf_parser_model i_par (.clk_sys(clk_sys), .frm_ready(frm_ready),
      .vrd_valid(vrd_valid), .vrd_forward(vrd_forward),
      .vrd_entry_number(vrd_entry_number), .frm_valid(frm_valid),
      .frm_vid(frm_vid), .frm_port(frm_port), .frm_etype(frm_etype),
      .frm_is_ipv4(frm_is_ipv4), .frm_sip(frm_sip), .frm_dip(frm_dip),
      .frm_frag(frm_frag), .frm_proto(frm_proto),
      .frm_l4_port(frm_l4_port), .frm_smac(frm_smac));
   // ----------------------------------------
   // bus, compare and frame helpers
   // ----------------------------------------
   task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
   endtask
   task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
   endtask
   task automatic chk_reg(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_vrd(input logic [8:0] got, exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ld(input logic [7:0] n, input logic [31:0] fl_v, s, sm,
      input logic [7:0] pr, input logic [31:0] l4, input logic [15:0] et);
      bus_wr(`PAF_OFS_FLAGS, fl_v);
      bus_wr(`PAF_OFS_SIP, s);
      bus_wr(`PAF_OFS_SMSK, sm);
      bus_wr(`PAF_OFS_PROTO, {24'h0, pr});
      bus_wr(`PAF_OFS_L4PORTS, l4);
      bus_wr(`PAF_OFS_ETYPE, {16'h0, et});
      bus_wr(`PAF_OFS_CMD, {23'h0, 1'b1, n});
   endtask
   task automatic fdef();
      fv = 12'h001;
      fp = 5'h01;
      fe = 16'h0800;
      f4 = 1'b1;
      fs = 32'h0;
      ff = 1'b0;
      fpr = 8'h06;
      fl = 16'h0;
      fm = 48'h0;
      fgap = 0;
   endtask
   task automatic frame(input logic ef, input logic [7:0] en);
      logic gf;
      logic [7:0] gn;
      i_par.send(fgap, fv, fp, fe, f4, fs, 32'h0, ff, fpr, fl, fm, gf, gn);
      chk_vrd({gf, gn}, {ef, en});
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [31:0] d;
      bus_rd(`PAF_OFS_FLAGS, d);
      chk_reg(d, 32'h0000_07B8);
      bus_rd(`PAF_OFS_SMSK, d);
      chk_reg(d, 32'hFFFF_FFFF);
      bus_rd(`PAF_OFS_MAC_LO, d);
      chk_reg(d, 32'h2233_4455);
      bus_rd(6'h3C, d);
      chk_reg(d, 32'h0);
      fdef();
      frame(1'b1, 8'h00);
   endtask
   task automatic t_prio();
      ld(8'h09, ANY, 0, 0, 0, 0, 0);
      ld(8'h05, (ANY & ~32'h8) | 32'h1 | (32'd4094 << 16), 0, 0, 0, 0, 0);
      fdef();
      fv = 12'd4094;
      frame(1'b0, 8'h05);
      fv = 12'd4093;
      frame(1'b1, 8'h09);
      ld(8'h03, (ANY & ~32'h10) | 32'h1, 32'h0A00_0005, 32'hFF00_00FF,
         0, 0, 0);
      fdef();
      fs = 32'h0A12_3405;
      frame(1'b0, 8'h03);
      fs = 32'h0A12_3404;
      frame(1'b1, 8'h09);
   endtask
   task automatic t_proto();
      logic [7:0] tbl [6] = '{8'h01, 8'h02, 8'h06, 8'h11, 8'hFF, 8'h00};
      foreach (tbl[i]) begin
         ld(8'h02, (ANY & ~32'h80) | 32'h1, 0, 0, tbl[i], 0, 0);
         fdef();
         fpr = tbl[i];
         frame(1'b0, 8'h02);
         fpr = tbl[i] ^ 8'h80;
         frame(1'b1, 8'h09);
      end
   endtask
   task automatic t_l4();
      logic [16:0] tbl [7] = '{{1'b0, 16'd21}, {1'b0, 16'd80},
         {1'b0, 16'hFFFF}, {1'b1, 16'd67}, {1'b1, 16'd69},
         {1'b1, 16'd137}, {1'b1, 16'h0000}};
      foreach (tbl[i]) begin
         if (tbl[i][16]) ld(8'h02, (ANY & ~32'h200) | 32'h1, 0, 0, 0,
            {tbl[i][15:0], 16'h0}, 0);
         else ld(8'h02, (ANY & ~32'h100) | 32'h1, 0, 0, 0,
            {16'h0, tbl[i][15:0]}, 0);
         fdef();
         fpr = tbl[i][16] ? 8'h11 : 8'h06;
         fl = tbl[i][15:0];
         frame(1'b0, 8'h02);
         fl = tbl[i][15:0] ^ 16'h8000;
         frame(1'b1, 8'h09);
         fpr = tbl[i][16] ? 8'h06 : 8'h11;
         fl = tbl[i][15:0];
         frame(1'b1, 8'h09);
      end
   endtask
   task automatic t_etype();
      logic [15:0] tbl [3] = '{16'h0806, 16'h8137, 16'hFFFF};
      foreach (tbl[i]) begin
         ld(8'h02, (ANY & ~32'h410) | 32'h3, 32'h0102_0304, 32'hFFFF_FFFF,
            0, 0, tbl[i]);
         fdef();
         f4 = 1'b0;
         fe = tbl[i];
         frame(1'b0, 8'h02);
         fe = tbl[i] ^ 16'h0001;
         frame(1'b1, 8'h00);
      end
   endtask
   task automatic t_fields();
      ld(8'h02, ANY | 32'h41, 0, 0, 0, 0, 0);
      fdef();
      frame(1'b1, 8'h09);
      ff = 1'b1;
      frame(1'b0, 8'h02);
      ld(8'h02, ANY | 32'h1 | (32'd26 << 11), 0, 0, 0, 0, 0);
      fdef();
      fp = 5'd26;
      frame(1'b0, 8'h02);
      fp = 5'd25;
      frame(1'b1, 8'h09);
   endtask
   task automatic t_bind();
      bus_wr(`PAF_OFS_MAC_LO, 32'h89AB_CDEF);
      bus_wr(`PAF_OFS_MAC_HI, 32'h0000_4567);
      ld(8'h02, (ANY & ~32'h10) | 32'h5 | (32'd3 << 11), 32'hC0A8_0001,
         32'hFFFF_FFFF, 0, 0, 0);
      fdef();
      fv = 12'h000;
      fp = 5'd3;
      fs = 32'hC0A8_0001;
      fm = 48'h4567_89AB_CDEF;
      frame(1'b0, 8'h02);
      fv = 12'h005;
      frame(1'b1, 8'h09);
      fv = 12'h000;
      fm = 48'h4567_89AB_CDEE;
      frame(1'b1, 8'h09);
   endtask
   task automatic t_ctrl();
      logic [31:0] d;
      bus_wr(`PAF_OFS_CTRL, 32'h0);
      fdef();
      fgap = 7;
      frame(1'b1, 8'h00);
      bus_wr(`PAF_OFS_CTRL, 32'h1);
      ld(8'h02, ANY | 32'h1, 0, 0, 0, 0, 0);
      frame(1'b0, 8'h02);
      bus_wr(`PAF_OFS_CMD, 32'h0000_0202);
      frame(1'b1, 8'h09);
      ld(8'hF7, ANY | 32'h3, 0, 0, 0, 0, 0);
      bus_rd(`PAF_OFS_STATUS, d);
      chk_reg(d & 32'h2, 32'h0);
      f4 = 1'b0;
      frame(1'b0, 8'hF7);
      bus_wr(`PAF_OFS_CMD, 32'h0000_01F8);
      bus_rd(`PAF_OFS_STATUS, d);
      chk_reg(d & 32'h2, 32'h2);
      bus_rd(`PAF_OFS_DROP_CNT, d);
      chk_reg(d, 32'h0000_0017);
      bus_rd(`PAF_OFS_FWD_CNT, d);
      chk_reg(d, 32'h0000_0020);
   endtask
   // ----------------------------------------
   // clock, run and verdict
   // ----------------------------------------
   task automatic summarize();
      $display("mismatches %0d comparisons %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      {err_total, checked, cyc} = '0;
      rst = 1'b1;
      {avs_read, avs_write, avs_address, avs_writedata} = '0;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_prio();
      t_proto();
      t_l4();
      t_etype();
      t_fields();
      t_bind();
      t_ctrl();
      summarize();
   end
endmodule
`default_nettype wire
